// File: core/psl_strap_latch.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module psl_strap_latch #(
  parameter int ADDR_W = psl_pkg::ADDR_W
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [psl_pkg::PAD_W-1:0] STRAP_PAD_I,
  input wire logic [psl_pkg::PAD_W-1:0] FUNC_PAD_I,
  output logic [psl_pkg::PAD_W-1:0] STRAP_PAD_O,
  output logic [psl_pkg::PAD_W-1:0] STRAP_PAD_OE_N_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [4:0] MGMT_ADDR_O,
  output logic [2:0] CFG_CODE_O,
  output logic MDIX_AUTO_EN_O,
  output logic CFG_RESERVED_O,
  output logic AUTO_NEGOTIATION_STRAP_EN_O,
  output logic SPEED_100_O,
  output logic FULL_DUPLEX_O,
  output logic [1:0] ADV_100_O,
  output logic [1:0] ADV_10_O,
  output logic TEST_TREE_EN_O,
  output logic LINE_FILTER_DIS_O,
  output logic ADDR_ZERO_UNIQUE_O,
  output logic STRAP_DONE_O
);
  import psl_pkg::*;

  psl_phase_type phase_r;
  logic [4:0] mgmt_addr_r;
  logic [2:0] cfg_r;
  logic mdix_r;
  logic rsvd_r;
  logic tree_r;
  logic filt_r;
  logic uniq_r;
  logic speed_r;
  logic aneg_r;
  logic fdx_r;
  logic [1:0] adv100_r;
  logic [1:0] adv10_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic load_en;
  logic [PAD_W-1:0] load_pad;
  logic [2:0] load_cfg;
  logic setup;
  logic wr_go;
  logic mapped;
  logic [31:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic cfg_mdix(input logic [2:0] c);
    return (c == CFG_MDIX_A) || (c == CFG_MDIX_B);
  endfunction

  function automatic logic cfg_rsvd(input logic [2:0] c);
    return !cfg_mdix(c) && (c != CFG_MII);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Latch phase: one capture cycle right after reset is released
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      phase_r <= PH_HOLD;
    end else begin
      case (phase_r)
        PH_HOLD: phase_r <= PH_RUN;
        PH_RUN: phase_r <= PH_RUN;
        default: phase_r <= PH_HOLD;
      endcase
    end
  end

  // In reset the registers take the pull defaults, a constant; the pads
  // themselves are only looked at on the first edge after release.
  assign load_en = RST_I || (phase_r == PH_HOLD);
  assign load_pad = RST_I ? PAD_DEFAULT : STRAP_PAD_I;
  assign load_cfg = {load_pad[PAD_CFG2], load_pad[PAD_CFG1],
                     load_pad[PAD_CFG0]};

  ////////////////////////////////////////////////////////////////////////////
  // Read-only strap settings
  always_ff @(posedge CORE_CLK_I) begin
    if (load_en) begin
      mgmt_addr_r <= {MGMT_ADDR_HI, load_pad[PAD_ADDR2],
                      load_pad[PAD_ADDR1], load_pad[PAD_ADDR0]};
    end
  end

  // Reserved codes fall back to crossover off and are flagged in status
  always_ff @(posedge CORE_CLK_I) begin
    if (load_en) begin
      cfg_r <= load_cfg;
      mdix_r <= cfg_mdix(load_cfg);
      rsvd_r <= cfg_rsvd(load_cfg);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (load_en) begin
      tree_r <= !load_pad[PAD_TREE_N];
      filt_r <= load_pad[PAD_FILT];
      uniq_r <= load_pad[PAD_BCAST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible control and advertisement bits seeded by straps, except ADV_10_O, which loads ADV_10_DEFAULT
  always_ff @(posedge CORE_CLK_I) begin
    if (load_en) begin
      speed_r <= load_pad[PAD_SPEED];
      aneg_r <= load_pad[PAD_ANEG];
      fdx_r <= !load_pad[PAD_DUPLEX];
    end else if (wr_go && hit(PADDR_I, OFS_CTRL)) begin
      speed_r <= PWDATA_I[CTRL_SPEED];
      aneg_r <= PWDATA_I[CTRL_ANEG];
      fdx_r <= PWDATA_I[CTRL_DUPLEX];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (load_en) begin
      adv100_r <= {2{load_pad[PAD_SPEED]}};
      adv10_r <= ADV_10_DEFAULT;
    end else if (wr_go && hit(PADDR_I, OFS_ADV)) begin
      adv100_r <= PWDATA_I[ADV_100_LO +: 2];
      adv10_r <= PWDATA_I[ADV_10_LO +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, answer registered at the setup edge
  assign setup = PSEL_I && !PENABLE_I;
  assign wr_go = PSEL_I && PENABLE_I && pready_r && PWRITE_I;
  assign mapped = hit(PADDR_I, OFS_CTRL) || hit(PADDR_I, OFS_ADV) ||
                  hit(PADDR_I, OFS_STRAP);

  always_comb begin
    rd_data = '0;
    if (hit(PADDR_I, OFS_CTRL)) begin
      rd_data[CTRL_SPEED] = speed_r;
      rd_data[CTRL_ANEG] = aneg_r;
      rd_data[CTRL_DUPLEX] = fdx_r;
    end else if (hit(PADDR_I, OFS_ADV)) begin
      rd_data[ADV_100_LO +: 2] = adv100_r;
      rd_data[ADV_10_LO +: 2] = adv10_r;
      rd_data[ADV_SEL_LO +: 5] = ADV_SELECTOR;
    end else if (hit(PADDR_I, OFS_STRAP)) begin
      rd_data[ST_ADDR_LO +: 5] = mgmt_addr_r;
      rd_data[ST_CFG_LO +: 3] = cfg_r;
      rd_data[ST_MDIX] = mdix_r;
      rd_data[ST_RSVD] = rsvd_r;
      rd_data[ST_TREE] = tree_r;
      rd_data[ST_FILT] = filt_r;
      rd_data[ST_UNIQ] = uniq_r;
      rd_data[ST_DONE] = (phase_r == PH_RUN);
    end
  end

  // Read data is snapped at setup; a setup in the capture cycle right after reset
  // returns the values loaded in reset from PAD_DEFAULT, with ST_DONE still 0.
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r <= PWRITE_I ? 32'h0 : rd_data;
    end else if (pready_r) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad direction: shared pins turn to outputs once the capture is done
  psl_pad_ctl #(
    .W(PAD_W)
  ) u_pad (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .drive_en_i(phase_r == PH_RUN),
    .func_i(FUNC_PAD_I),
    .pad_o(STRAP_PAD_O),
    .pad_oe_n_o(STRAP_PAD_OE_N_O)
  );

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign MGMT_ADDR_O = mgmt_addr_r;
  assign CFG_CODE_O = cfg_r;
  assign MDIX_AUTO_EN_O = mdix_r;
  assign CFG_RESERVED_O = rsvd_r;
  assign AUTO_NEGOTIATION_STRAP_EN_O = aneg_r;
  assign SPEED_100_O = speed_r;
  assign FULL_DUPLEX_O = fdx_r;
  assign ADV_100_O = adv100_r;
  assign ADV_10_O = adv10_r;
  assign TEST_TREE_EN_O = tree_r;
  assign LINE_FILTER_DIS_O = filt_r;
  assign ADDR_ZERO_UNIQUE_O = uniq_r;
  assign STRAP_DONE_O = (phase_r == PH_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic [PAD_W-1:0] pad_q;
  logic cap_w;

  always_ff @(posedge CORE_CLK_I) begin
    pad_q <= STRAP_PAD_I;
  end

  assign cap_w = !RST_I && (phase_r == PH_HOLD);

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  property p_addr_capture;
    cap_w |=> MGMT_ADDR_O == {MGMT_ADDR_HI, pad_q[PAD_ADDR2],
                              pad_q[PAD_ADDR1], pad_q[PAD_ADDR0]};
  endproperty
  a_addr_capture: assert property (p_addr_capture)
    else $error("management address not taken from straps");

  property p_addr_default;
    disable iff (1'b0) RST_I |=> MGMT_ADDR_O == MGMT_ADDR_DEFAULT;
  endproperty
  a_addr_default: assert property (p_addr_default)
    else $error("default management address wrong");

  property p_addr_hi;
    MGMT_ADDR_O[4:3] == MGMT_ADDR_HI;
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("upper management address bits not zero");

  property p_mode;
    cap_w |=> CFG_CODE_O == {pad_q[PAD_CFG2], pad_q[PAD_CFG1],
                             pad_q[PAD_CFG0]} &&
      MDIX_AUTO_EN_O == (CFG_CODE_O == CFG_MDIX_A ||
                         CFG_CODE_O == CFG_MDIX_B);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode strap decode wrong");

  property p_ctrl_capture;
    cap_w |=> AUTO_NEGOTIATION_STRAP_EN_O == pad_q[PAD_ANEG] &&
      SPEED_100_O == pad_q[PAD_SPEED] &&
      FULL_DUPLEX_O == !pad_q[PAD_DUPLEX];
  endproperty
  a_ctrl_capture: assert property (p_ctrl_capture)
    else $error("control bits not seeded from straps");

  property p_adv_speed;
    cap_w |=> ADV_100_O == {2{SPEED_100_O}};
  endproperty
  a_adv_speed: assert property (p_adv_speed)
    else $error("advertised speed does not follow speed strap");

  property p_misc_capture;
    cap_w |=> TEST_TREE_EN_O == !pad_q[PAD_TREE_N] &&
      LINE_FILTER_DIS_O == pad_q[PAD_FILT] &&
      ADDR_ZERO_UNIQUE_O == pad_q[PAD_BCAST];
  endproperty
  a_misc_capture: assert property (p_misc_capture)
    else $error("option strap latched wrong");

  property p_pad_dir;
    cap_w |-> STRAP_PAD_OE_N_O == '1 ##1 STRAP_PAD_OE_N_O == '1
      ##1 STRAP_PAD_OE_N_O == '0;
  endproperty
  a_pad_dir: assert property (p_pad_dir)
    else $error("strap pads not released to outputs on time");

  property p_hold;
    phase_r == PH_RUN |=> $stable(MGMT_ADDR_O) && $stable(CFG_CODE_O) &&
      $stable(TEST_TREE_EN_O) && $stable(LINE_FILTER_DIS_O) &&
      $stable(ADDR_ZERO_UNIQUE_O) && STRAP_PAD_OE_N_O == '0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("strap setting changed after capture");

  property p_ctrl_keep;
    phase_r == PH_RUN && !wr_go |=> $stable(SPEED_100_O) &&
      $stable(AUTO_NEGOTIATION_STRAP_EN_O) && $stable(FULL_DUPLEX_O);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("control bit changed without a write");

  property p_apb_answer;
    setup |=> PREADY_O ##1 !PREADY_O;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer timing wrong");

  c_mdix: cover property (cap_w ##1 MDIX_AUTO_EN_O);
  c_reserved: cover property (cap_w ##1 CFG_RESERVED_O);
  c_ctrl_write: cover property (wr_go && hit(PADDR_I, OFS_CTRL));
  c_unmapped: cover property (PREADY_O && PSLVERR_O);

endmodule
`default_nettype wire

// File: core/psl_pkg.sv
`default_nettype none
package psl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pad positions in the pad vectors
  localparam int PAD_W = 12;
  localparam int PAD_ADDR2 = 0;
  localparam int PAD_ADDR1 = 1;
  localparam int PAD_ADDR0 = 2;
  localparam int PAD_CFG2 = 3;
  localparam int PAD_CFG1 = 4;
  localparam int PAD_CFG0 = 5;
  localparam int PAD_ANEG = 6;
  localparam int PAD_TREE_N = 7;
  localparam int PAD_FILT = 8;
  localparam int PAD_SPEED = 9;
  localparam int PAD_DUPLEX = 10;
  localparam int PAD_BCAST = 11;

  // Levels that the internal pulls give with nothing fitted on the board
  localparam logic [11:0] PAD_DEFAULT = 12'h6c4;

  ////////////////////////////////////////////////////////////////////////////
  // Management address and mode codes
  localparam logic [1:0] MGMT_ADDR_HI = 2'h0;
  localparam logic [4:0] MGMT_ADDR_DEFAULT = 5'h01;
  localparam logic [2:0] CFG_MII = 3'h0;
  localparam logic [2:0] CFG_MDIX_A = 3'h2;
  localparam logic [2:0] CFG_MDIX_B = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses, one 32-bit word each)
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADV = 12'h004;
  localparam logic [11:0] OFS_STRAP = 12'h008;

  localparam int CTRL_SPEED = 13;
  localparam int CTRL_ANEG = 12;
  localparam int CTRL_DUPLEX = 8;

  localparam int ADV_100_LO = 7;
  localparam int ADV_10_LO = 5;
  localparam int ADV_SEL_LO = 0;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [1:0] ADV_10_DEFAULT = 2'h3;

  localparam int ST_ADDR_LO = 0;
  localparam int ST_CFG_LO = 5;
  localparam int ST_MDIX = 8;
  localparam int ST_RSVD = 9;
  localparam int ST_TREE = 10;
  localparam int ST_FILT = 11;
  localparam int ST_UNIQ = 12;
  localparam int ST_DONE = 13;

  typedef enum logic {PH_HOLD, PH_RUN} psl_phase_type;

endpackage
`default_nettype wire

// File: core/psl_pad_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module psl_pad_ctl #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic drive_en_i,
  input wire logic [W-1:0] func_i,
  output logic [W-1:0] pad_o,
  output logic [W-1:0] pad_oe_n_o
);

  // Pads float as inputs while in reset so the pulls set the level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_oe_n_o <= '1;
    end else begin
      pad_oe_n_o <= {W{~drive_en_i}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= '0;
    end else begin
      pad_o <= func_i;
    end
  end

endmodule
`default_nettype wire

// File: testbench/psl_board.sv
`timescale 1ns/1ps
`default_nettype none
module psl_board (
  input wire logic [psl_pkg::PAD_W-1:0] strap_i,
  input wire logic [psl_pkg::PAD_W-1:0] pad_o_i,
  input wire logic [psl_pkg::PAD_W-1:0] pad_oe_n_i,
  output logic [psl_pkg::PAD_W-1:0] pad_lvl_o
);
  import psl_pkg::*;
  // The board passes any mode code on the config straps; the tests latch only the legal codes 0, 2 and 6.
  // Undriven pads settle to the fitted pull, driven ones follow the chip.
  always_comb begin
    for (int k = 0; k < PAD_W; k++) begin
      pad_lvl_o[k] = pad_oe_n_i[k] ? strap_i[k] : pad_o_i[k];
    end
  end
endmodule
`default_nettype wire

// File: testbench/psl_strap_latch_test.sv
`timescale 1ns/1ps
`default_nettype none
module psl_strap_latch_test;
  import psl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] strap = PAD_DEFAULT;
  logic [11:0] func = 12'ha5c;
  logic [11:0] pad_in, pad_out, pad_oe_n;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mdix, rsvd, aneg, spd, fdx, tree, filt, uniq, done;
  logic [4:0] maddr;
  logic [2:0] cfg;
  logic [1:0] adv100, adv10;
  int err_total = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  psl_strap_latch psl_strap_latch_inst (.CORE_CLK_I(clk), .RST_I(rst),
    .STRAP_PAD_I(pad_in), .FUNC_PAD_I(func), .STRAP_PAD_O(pad_out),
    .STRAP_PAD_OE_N_O(pad_oe_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MGMT_ADDR_O(maddr), .CFG_CODE_O(cfg), .MDIX_AUTO_EN_O(mdix),
    .CFG_RESERVED_O(rsvd), .AUTO_NEGOTIATION_STRAP_EN_O(aneg), .SPEED_100_O(spd),
    .FULL_DUPLEX_O(fdx), .ADV_100_O(adv100), .ADV_10_O(adv10),
    .TEST_TREE_EN_O(tree), .LINE_FILTER_DIS_O(filt),
    .ADDR_ZERO_UNIQUE_O(uniq), .STRAP_DONE_O(done));

  psl_board psl_board_inst (.strap_i(strap), .pad_o_i(pad_out),
    .pad_oe_n_i(pad_oe_n), .pad_lvl_o(pad_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x,
                     input string m);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask

  // Waits for the answer however long; only the watchdog ends a dead bus
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic [11:0] s);
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic check_all(input logic [11:0] s);
    logic [31:0] q;
    logic e;
    logic [2:0] c;
    logic mx;
    c = {s[PAD_CFG2], s[PAD_CFG1], s[PAD_CFG0]};
    mx = (c == CFG_MDIX_A) || (c == CFG_MDIX_B);
    @(negedge clk);
    chk({maddr, cfg, mdix, rsvd, aneg, spd, fdx, adv100, adv10, tree, filt,
      uniq, done}, {MGMT_ADDR_HI, s[0], s[1], s[2], c, mx, 1'b0, s[6], s[9],
      ~s[10], {2{s[9]}}, ADV_10_DEFAULT, ~s[7], s[8], s[11], 1'b1},
      "decode");
    apb(1'b0, OFS_STRAP, 32'h0, q, e);
    chk(q, {18'h0, 1'b1, s[11], s[8], ~s[7], 1'b0, mx, c, MGMT_ADDR_HI,
      s[0], s[1], s[2]}, "status");
    apb(1'b0, OFS_CTRL, 32'h0, q, e);
    chk(q, {18'h0, s[9], s[6], 3'h0, ~s[10], 8'h00}, "ctrl");
    apb(1'b0, OFS_ADV, 32'h0, q, e);
    chk(q, {23'h0, {2{s[9]}}, ADV_10_DEFAULT, ADV_SELECTOR}, "adv");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_default();
    do_reset(PAD_DEFAULT);
    @(negedge clk);
    chk(maddr, MGMT_ADDR_DEFAULT, "default address");
    check_all(PAD_DEFAULT);
  endtask

  // Every address; codes CFG_MII, CFG_MDIX_A and CFG_MDIX_B; other straps follow the address bits
  task automatic t_sweep();
    logic [2:0] codes [3];
    logic [11:0] s;
    codes = '{CFG_MII, CFG_MDIX_A, CFG_MDIX_B};
    for (int i = 0; i < 8; i++) begin
      s = {i[0], ~i[1], i[2], i[1], ~i[0], ~i[2], codes[i % 3][0],
        codes[i % 3][1], codes[i % 3][2], i[0], i[1], i[2]};
      do_reset(s);
      check_all(s);
    end
  endtask

  task automatic t_pads();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    chk({pad_oe_n, done}, {12'hfff, 1'b0}, "pads in reset");
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({pad_oe_n, done}, {12'hfff, 1'b1}, "pads at capture");
    @(negedge clk);
    chk(pad_oe_n, 12'h000, "pads driven");
    chk(pad_out, func, "pad data");
    chk(pad_in, func, "pad level");
  endtask

  task automatic t_hold();
    logic [31:0] q;
    logic e;
    logic [11:0] s;
    s = 12'h9c0;
    do_reset(s);
    strap <= ~s;
    repeat (5) @(posedge clk);
    check_all(s);
    apb(1'b1, OFS_STRAP, 32'hffffffff, q, e);
    apb(1'b0, OFS_STRAP, 32'h0, q, e);
    chk(q[13:0], {1'b1, s[11], s[8], ~s[7], 2'b00, s[3], s[4], s[5], 2'b00,
      s[0], s[1], s[2]}, "status read only");
    apb(1'b1, OFS_CTRL, 32'h00002100, q, e);
    @(negedge clk);
    chk({spd, aneg, fdx}, 3'h5, "ctrl rewrite");
    apb(1'b1, OFS_ADV, 32'h0, q, e);
    apb(1'b0, OFS_ADV, 32'h0, q, e);
    chk(q, {27'h0, ADV_SELECTOR}, "adv rewrite");
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk({e, q}, {1'b1, 32'h0}, "unmapped read");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_default();
    t_sweep();
    t_pads();
    t_hold();
    stop_test();
  end

  initial begin
    #400000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
